//--- rtl/deep_sleep_pkg.sv
// package: register map, field positions and timing constants of the deep sleep exit block
package deep_sleep_pkg;
   // ***************************************************
   // register byte offsets (apb, one word each)
   // ***************************************************
   localparam logic [7:0] OFF_RESET_CONTROL = 8'h00;   // reset_control_register
   localparam logic [7:0] OFF_SLEEP_CONTROL = 8'h04;   // deep_sleep_control_register
   localparam logic [7:0] OFF_WAKE_SOURCE = 8'h08;     // wake_source_register
   localparam logic [7:0] OFF_CONTEXT_A = 8'h0c;       // context_register_a
   localparam logic [7:0] OFF_CONTEXT_B = 8'h10;       // context_register_b
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;      // sticky event status, write one to clear
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;        // event mask, same layout
   localparam logic [7:0] OFF_INT_ENABLE = 8'h1c;      // external interrupt enable and polarity
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int BIT_EXIT_FLAG = 10;     // deep_sleep_exit_flag in reset control
   localparam int BIT_RELEASE = 0;        // release bit in sleep control
   localparam int BIT_BROWNOUT = 1;       // deep_sleep_brownout_flag in sleep control
   localparam int BIT_WATCHDOG_FLAG = 2;  // preserved watchdog flag in sleep control
   localparam int BIT_ENABLE = 15;        // deep_sleep_enable in sleep control
   localparam int BIT_INT_EN = 0;         // interrupt zero enable
   localparam int BIT_INT_POL = 1;        // interrupt zero polarity (1 = active high)
   // wake source bit order
   localparam int WAKE_POR = 0;
   localparam int WAKE_WDT = 1;
   localparam int WAKE_RTC = 2;
   localparam int WAKE_MASTER_CLEAR_PIN_N = 3;
   localparam int WAKE_EXTERNAL_INTERRUPT_ZERO_PIN = 4;
   localparam int NUM_WAKE = 5;
   // interrupt status bits
   localparam int EV_WAKE = 0;    // a deep sleep exit completed
   localparam int EV_ENTRY = 1;   // deep sleep was entered
   localparam int NUM_EV = 2;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLOCK_MHZ = 125;
   localparam int POR_TIME_US = 64;  // power-on reset time, plain default
   localparam int POR_CYCLES = POR_TIME_US * CLOCK_MHZ;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_POR} sleep_state_t;
   // wake inputs grouped together
   typedef struct packed {
      logic supplyPor;
      logic watchdogTimeout;
      logic rtcAlarm;
      logic masterClearPinN;
      logic extIntPin;
   } wake_in_t;
endpackage

//--- rtl/deep_sleep_wake_exit.sv
// deep sleep exit controller with apb register access
//
// Functional notes
// - supply power-on reset wakes the device
// - watchdog timeout wakes the device
// - rtc alarm wakes only with rtc_enable set
// - low master clear pin wakes the device
// - enabled interrupt zero change wakes, polarity chosen
// - pending interrupts discarded on sleep entry
// - every exit acts as full power-on reset
// - rtc, context registers, watchdog flag preserved
// - wakes ignored until reset sequence finishes
// - wake resets, clears enable, restarts at vector
// - exit flag bit 10 set; software clears
// - wake cause recorded in wake source register
// - brownout during sleep sets sleep control bit 1
// - context registers retained during deep sleep
// - wake delay equals power-on reset time
// - outputs hold entry latch, inputs stay floating
`timescale 1ns/1ps
module deep_sleep_wake_exit
   import deep_sleep_pkg::*;
#(
   parameter int PIN_COUNT = 8,
   parameter int POR_COUNT = POR_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // wake sources
   input wire wake_in_t wakeIn,
   input wire logic rtcEnable,
   input wire logic brownoutDetect,
   input wire logic sleepRequest,
   // interrupt requests pending in the core, cleared on entry
   input wire logic intPending,
   output logic intFlush,
   // device reset and status
   output logic deviceResetN,
   output logic rtcRunning,
   output logic irq,
   // gpio hold
   input wire logic [PIN_COUNT-1:0] pinDirectionBit,
   input wire logic [PIN_COUNT-1:0] outputLatchBit,
   output logic [PIN_COUNT-1:0] pinOut,
   output logic [PIN_COUNT-1:0] pinOe
);
   // ***************************************************
   // state and registers
   // ***************************************************
   sleep_state_t state_reg;               // sequencer state
   logic [31:0] porCount_reg;             // reset sequence counter
   logic exitFlag_reg;                    // deep_sleep_exit_flag
   logic release_reg;                     // release bit
   logic brownout_reg;                    // deep_sleep_brownout_flag
   logic watchdogFlag_reg;                // preserved watchdog flag
   logic enable_reg;                      // deep_sleep_enable
   logic [NUM_WAKE-1:0] wakeSource_reg;   // wake_source_register
   logic [31:0] contextA_reg;             // context_register_a
   logic [31:0] contextB_reg;             // context_register_b
   logic [NUM_EV-1:0] irqStatus_reg;      // sticky events
   logic [NUM_EV-1:0] irqMask_reg;        // event mask
   logic intEnable_reg;                   // interrupt zero enable
   logic intPolarity_reg;                 // interrupt zero polarity
   logic intArmed_reg;                    // enable latched at entry
   logic intPrev_reg;                     // interrupt pin last value
   logic intChanged_reg;                  // pin changed while asleep
   logic [PIN_COUNT-1:0] holdOut_reg;     // latch level at entry
   logic [PIN_COUNT-1:0] holdOe_reg;      // direction at entry

   // ***************************************************
   // bus decode
   // ***************************************************
   logic wrEn;
   logic rdEn;
   logic [NUM_WAKE-1:0] wakeHit;
   logic wakeAny;
   logic wake1clr;  // wake source read clears it
   logic wakeEvent;
   logic entryEvent;
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && penable && !pwrite;
   assign wake1clr = rdEn && (paddr == OFF_WAKE_SOURCE);

   // wake qualification, only looked at in sleep state so late events drop out
   always_comb begin
      wakeHit = '0;
      wakeHit[WAKE_POR] = wakeIn.supplyPor;
      wakeHit[WAKE_WDT] = wakeIn.watchdogTimeout;
      wakeHit[WAKE_RTC] = wakeIn.rtcAlarm && rtcEnable;
      wakeHit[WAKE_MASTER_CLEAR_PIN_N] = !wakeIn.masterClearPinN;
      // level must match polarity and a change must have been seen asleep
      wakeHit[WAKE_EXTERNAL_INTERRUPT_ZERO_PIN] = intArmed_reg && (intChanged_reg || (wakeIn.extIntPin != intPrev_reg))
         && (wakeIn.extIntPin == intPolarity_reg);
   end
   assign wakeAny = |wakeHit;
   assign wakeEvent = (state_reg == ST_SLEEP) && wakeAny;
   assign entryEvent = (state_reg == ST_RUN) && enable_reg && sleepRequest;

   // ***************************************************
   // sequencer
   // ***************************************************
   // sleep, then a full reset sequence of por length before run resumes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= ST_RUN;
         porCount_reg <= ZERO_WORD;
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (entryEvent) begin
                  state_reg <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (wakeAny) begin
                  state_reg <= ST_POR;
                  porCount_reg <= ZERO_WORD;
               end
            end
            ST_POR: begin
               // wake delay is exactly the reset time
               if (porCount_reg == 32'(POR_COUNT - 1)) begin
                  state_reg <= ST_RUN;
               end else begin
                  porCount_reg <= porCount_reg + 32'h0000_0001;
               end
            end
            default: begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   // device reset held low through the reset sequence, core restarts at vector
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         deviceResetN <= 1'b0;
      end else begin
         // low from the wake edge for exactly the reset time; rises as the last count is reached
         deviceResetN <= !(wakeEvent || ((state_reg == ST_POR) && (porCount_reg != 32'(POR_COUNT - 1))));
      end
   end

   // rtc never stopped by sleep or exit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rtcRunning <= 1'b0;
      end else begin
         rtcRunning <= rtcEnable;
      end
   end

   // pending interrupts flushed as sleep is entered
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         intFlush <= 1'b0;
      end else begin
         intFlush <= entryEvent && intPending;
      end
   end

   // ***************************************************
   // interrupt zero tracking
   // ***************************************************
   // arming is frozen at entry; a change must happen after entry
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         intArmed_reg <= 1'b0;
         intPrev_reg <= 1'b0;
         intChanged_reg <= 1'b0;
      end else begin
         intPrev_reg <= wakeIn.extIntPin;
         if (entryEvent) begin
            intArmed_reg <= intEnable_reg;
            intChanged_reg <= 1'b0;
         end else if (state_reg == ST_SLEEP && wakeIn.extIntPin != intPrev_reg) begin
            intChanged_reg <= 1'b1;
         end else if (state_reg == ST_RUN) begin
            intArmed_reg <= 1'b0;
         end
      end
   end

   // ***************************************************
   // pin hold
   // ***************************************************
   // outputs keep the latch value of entry, inputs keep floating
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         holdOut_reg <= '0;
         holdOe_reg <= '0;
         pinOut <= '0;
         pinOe <= '0;
      end else begin
         if (entryEvent) begin
            holdOut_reg <= outputLatchBit;
            holdOe_reg <= ~pinDirectionBit;
         end
         if (state_reg == ST_SLEEP) begin
            pinOut <= holdOut_reg;
            pinOe <= holdOe_reg;
         end else begin
            pinOut <= outputLatchBit;
            pinOe <= ~pinDirectionBit;
         end
      end
   end

   // ***************************************************
   // retained status and control
   // ***************************************************
   // these bits live in the always-on domain: the exit reset does not touch them
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         exitFlag_reg <= 1'b0;
         wakeSource_reg <= '0;
         brownout_reg <= 1'b0;
         watchdogFlag_reg <= 1'b0;
         release_reg <= 1'b0;
         enable_reg <= 1'b0;
      end else begin
         // software clear, set below wins
         if (wrEn && paddr == OFF_RESET_CONTROL && !pwdata[BIT_EXIT_FLAG]) begin
            exitFlag_reg <= 1'b0;
         end
         if (wake1clr) begin
            wakeSource_reg <= '0;
         end
         if (wrEn && paddr == OFF_SLEEP_CONTROL) begin
            enable_reg <= pwdata[BIT_ENABLE];
            if (!pwdata[BIT_RELEASE]) begin
               release_reg <= 1'b0;
            end
            if (!pwdata[BIT_BROWNOUT]) begin
               brownout_reg <= 1'b0;
            end
         end
         if (entryEvent) begin
            release_reg <= 1'b1;      // status bit only; the pins are held just while asleep
         end
         if (state_reg == ST_SLEEP && brownoutDetect) begin
            brownout_reg <= 1'b1;
         end
         // only the first qualified event in sleep is captured
         if (wakeEvent) begin
            exitFlag_reg <= 1'b1;
            wakeSource_reg <= wakeHit;
            enable_reg <= 1'b0;
            watchdogFlag_reg <= wakeHit[WAKE_WDT];
         end
      end
   end

   // context registers written only by software, kept through sleep and exit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         contextA_reg <= ZERO_WORD;
         contextB_reg <= ZERO_WORD;
      end else begin
         if (wrEn && paddr == OFF_CONTEXT_A) begin
            contextA_reg <= pwdata;
         end
         if (wrEn && paddr == OFF_CONTEXT_B) begin
            contextB_reg <= pwdata;
         end
      end
   end

   // interrupt zero configuration; lost on the exit reset like other core state
   always_ff @(posedge clock) begin
      if (!rst_n || (state_reg == ST_POR)) begin
         intEnable_reg <= 1'b0;
         intPolarity_reg <= 1'b0;
      end else if (wrEn && paddr == OFF_INT_ENABLE) begin
         intEnable_reg <= pwdata[BIT_INT_EN];
         intPolarity_reg <= pwdata[BIT_INT_POL];
      end
   end

   // ***************************************************
   // interrupt status and mask
   // ***************************************************
   logic [NUM_EV-1:0] evSet;
   assign evSet = {entryEvent, (state_reg == ST_POR) && (porCount_reg == 32'(POR_COUNT - 1))};
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqStatus_reg <= '0;
         irqMask_reg <= '0;
      end else begin
         // set beats a write-one clear in the same cycle
         if (wrEn && paddr == OFF_IRQ_STATUS) begin
            irqStatus_reg <= (irqStatus_reg & ~pwdata[NUM_EV-1:0]) | evSet;
         end else begin
            irqStatus_reg <= irqStatus_reg | evSet;
         end
         if (wrEn && paddr == OFF_IRQ_MASK) begin
            irqMask_reg <= pwdata[NUM_EV-1:0];
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatus_reg & irqMask_reg);
      end
   end

   // ***************************************************
   // apb read and answer
   // ***************************************************
   // answer in the first access cycle; unmapped reads zero with slverr
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata <= ZERO_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= ZERO_WORD;
         if (psel && !penable) begin
            if (paddr == OFF_RESET_CONTROL) begin
               prdata[BIT_EXIT_FLAG] <= exitFlag_reg;
            end else if (paddr == OFF_SLEEP_CONTROL) begin
               prdata[BIT_ENABLE] <= enable_reg;
               prdata[BIT_WATCHDOG_FLAG] <= watchdogFlag_reg;
               prdata[BIT_BROWNOUT] <= brownout_reg;
               prdata[BIT_RELEASE] <= release_reg;
            end else if (paddr == OFF_WAKE_SOURCE) begin
               prdata[NUM_WAKE-1:0] <= wakeSource_reg;
            end else if (paddr == OFF_CONTEXT_A) begin
               prdata <= contextA_reg;
            end else if (paddr == OFF_CONTEXT_B) begin
               prdata <= contextB_reg;
            end else if (paddr == OFF_IRQ_STATUS) begin
               prdata[NUM_EV-1:0] <= irqStatus_reg;
            end else if (paddr == OFF_IRQ_MASK) begin
               prdata[NUM_EV-1:0] <= irqMask_reg;
            end else if (paddr == OFF_INT_ENABLE) begin
               prdata[BIT_INT_EN] <= intEnable_reg;
               prdata[BIT_INT_POL] <= intPolarity_reg;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule // deep_sleep_wake_exit

//--- test/deep_sleep_wake_exit_sva.sv
// checker: concurrent properties on the deep sleep exit block ports
`timescale 1ns/1ps
module deep_sleep_wake_exit_sva
   import deep_sleep_pkg::*;
#(
   parameter int PIN_COUNT = 8,
   parameter int POR_COUNT = POR_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire wake_in_t wakeIn,
   input wire logic rtcEnable,
   input wire logic sleepRequest,
   input wire logic intPending,
   input wire logic intFlush,
   input wire logic deviceResetN,
   input wire logic [PIN_COUNT-1:0] pinOut,
   input wire logic [PIN_COUNT-1:0] pinOe
);
   // ********************
   // mirror of the sleep state
   // ********************
   logic enSeen; // enable bit as last written
   logic sleeping; // device is asleep
   logic woke; // exit seen, flag not yet cleared
   int lowCount; // samples with device reset low
   // mirror clears on any device reset, since the exit also drops the enable
   always_ff @(posedge clock) begin
      if (!rst_n || !deviceResetN) begin
         enSeen <= 1'b0;
         sleeping <= 1'b0;
      end else begin
         if (psel && penable && pwrite && paddr == OFF_SLEEP_CONTROL) enSeen <= pwdata[BIT_ENABLE];
         if (enSeen && sleepRequest) sleeping <= 1'b1;
      end
   end
   // length of the current device reset
   always_ff @(posedge clock) begin
      if (!rst_n || deviceResetN) lowCount <= 0;
      else lowCount <= lowCount + 1;
   end
   // exit flag owed to software until it writes zero
   always_ff @(posedge clock) begin
      if (!rst_n) woke <= 1'b0;
      else if ($fell(deviceResetN)) woke <= 1'b1;
      else if (psel && penable && pwrite && paddr == OFF_RESET_CONTROL && !pwdata[BIT_EXIT_FLAG]) woke <= 1'b0;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   por_wake_a: assert property (sleeping && wakeIn.supplyPor |-> ##[1:2] !deviceResetN)
      else $error("supply event did not wake");
   wdt_wake_a: assert property (sleeping && wakeIn.watchdogTimeout |-> ##[1:2] !deviceResetN)
      else $error("watchdog timeout did not wake");
   rtc_wake_a: assert property (sleeping && wakeIn.rtcAlarm && rtcEnable |-> ##[1:2] !deviceResetN)
      else $error("enabled alarm did not wake");
   pin_wake_a: assert property (sleeping && !wakeIn.masterClearPinN |-> ##[1:2] !deviceResetN)
      else $error("master clear did not wake");
   entry_flush_a: assert property (enSeen && sleepRequest && !sleeping && intPending |-> ##1 intFlush)
      else $error("pending request not flushed at entry");
   wake_len_a: assert property ($rose(deviceResetN) && $past(rst_n, 2) |-> lowCount == POR_COUNT)
      else $error("exit reset length wrong");
   exit_flag_a: assert property (pready && !pwrite && paddr == OFF_RESET_CONTROL && woke |-> prdata[BIT_EXIT_FLAG])
      else $error("exit flag not reported");
   pin_hold_a: assert property (sleeping && $past(sleeping) |-> $stable(pinOut) && $stable(pinOe))
      else $error("pins moved while asleep");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   unmapped_a: assert property (pready && !pwrite && paddr > OFF_INT_ENABLE |-> pslverr && prdata == ZERO_WORD)
      else $error("unmapped read not refused");
   cover property (sleeping ##1 !deviceResetN);
   cover property (intFlush);
   cover property (pready && pslverr);
endmodule // deep_sleep_wake_exit_sva
bind deep_sleep_wake_exit deep_sleep_wake_exit_sva #(.PIN_COUNT(PIN_COUNT), .POR_COUNT(POR_COUNT))
   i_deep_sleep_wake_exit_sva (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wakeIn(wakeIn),
   .rtcEnable(rtcEnable), .sleepRequest(sleepRequest), .intPending(intPending), .intFlush(intFlush),
   .deviceResetN(deviceResetN), .pinOut(pinOut), .pinOe(pinOe));

//--- test/wake_source_model.sv
// partner model: the wake sources outside the device
`timescale 1ns/1ps
module wake_source_model
   import deep_sleep_pkg::*;
(
   input wire logic clock,
   input wire logic [NUM_WAKE-1:0] fire,
   input wire logic intActiveHigh,
   output wake_in_t wakeIn
);
   // ********************
   // source drivers
   // ********************
   // sources start quiet so nothing wakes before a source is fired
   initial wakeIn = 5'b00010;
   // one line per source; the pin idles at the inactive level, so firing is a real change
   always @(posedge clock) begin
      wakeIn.supplyPor <= fire[WAKE_POR];
      wakeIn.watchdogTimeout <= fire[WAKE_WDT];
      wakeIn.rtcAlarm <= fire[WAKE_RTC];
      wakeIn.masterClearPinN <= !fire[WAKE_MASTER_CLEAR_PIN_N];
      wakeIn.extIntPin <= fire[WAKE_EXTERNAL_INTERRUPT_ZERO_PIN] ~^ intActiveHigh;
   end
endmodule // wake_source_model

//--- test/deep_sleep_wake_exit_tb.sv
// testbench: deep sleep entry and exit through every wake source
`timescale 1ns/1ps
module deep_sleep_wake_exit_tb
   import deep_sleep_pkg::*;
;
   // ********************
   // stimulus and wiring
   // ********************
   localparam int POR_N = 10; // shortened exit reset
   localparam logic [31:0] CTX_A = 32'h1234_5678; // context words to survive exits
   localparam logic [31:0] CTX_B = 32'h9abc_def0;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lastErr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, intFlush, deviceResetN, rtcRunning, irq;
   logic rtcEnable = 1'b1, brownoutDetect = 1'b0, sleepRequest = 1'b0, intPending = 1'b0, intActiveHigh = 1'b1;
   logic [7:0] pinDirectionBit = 8'h0f, outputLatchBit = 8'ha5, pinOut, pinOe;
   logic [NUM_WAKE-1:0] fire = '0;
   wake_in_t wakeIn;
   int bad_count = 0;
   int cmp_count = 0;
   always #4 clock = ~clock;
   wake_source_model i_wake_source_model (.clock(clock), .fire(fire), .intActiveHigh(intActiveHigh), .wakeIn(wakeIn));
   deep_sleep_wake_exit #(.PIN_COUNT(8), .POR_COUNT(POR_N)) i_deep_sleep_wake_exit (.clock(clock), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wakeIn(wakeIn), .rtcEnable(rtcEnable), .brownoutDetect(brownoutDetect),
      .sleepRequest(sleepRequest), .intPending(intPending), .intFlush(intFlush), .deviceResetN(deviceResetN),
      .rtcRunning(rtcRunning), .irq(irq), .pinDirectionBit(pinDirectionBit), .outputLatchBit(outputLatchBit),
      .pinOut(pinOut), .pinOe(pinOe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; waits for ready, never assumes a latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      check(32'(pready), 32'h1);
      q = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic apbWrite(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      check(q & mask, exp);
   endtask
   // every register starts cleared; unmapped places are refused
   task automatic regValues();
      for (int a = 0; a <= 28; a += 4) rdChk(8'(a), 32'h0, '1);
      rdChk(8'h20, 32'h0, '1);
      check(32'(lastErr), 32'h1);
      apbWrite(8'h24, '1);
      check(32'(lastErr), 32'h1);
   endtask
   // enter sleep, hold the pins, wake from one source, then do the firmware follow-up
   task automatic wakeCycle(input int src, input logic pol);
      int n = 0;
      intActiveHigh <= pol;
      apbWrite(OFF_INT_ENABLE, {30'h0, pol, 1'b1});
      intPending <= 1'b1;
      apbWrite(OFF_SLEEP_CONTROL, 32'h0000_8000);
      @(posedge clock);
      sleepRequest <= 1'b1;
      @(posedge clock);
      sleepRequest <= 1'b0;
      @(posedge clock);
      check(32'(intFlush), 32'h1);
      intPending <= 1'b0;
      pinDirectionBit <= 8'hf0;
      outputLatchBit <= 8'h3c;
      brownoutDetect <= (src == WAKE_WDT);
      repeat (3) @(posedge clock);
      check(32'(pinOe), 32'hf0);
      check(32'(pinOut & pinOe), 32'ha0);
      check(32'(rtcRunning), 32'h1);
      brownoutDetect <= 1'b0;
      pinDirectionBit <= 8'h0f;
      outputLatchBit <= 8'ha5;
      // an alarm with the clock disabled must not wake
      if (src == WAKE_RTC) begin
         rtcEnable <= 1'b0;
         fire <= 5'(1 << src);
         repeat (4) @(posedge clock);
         check(32'(deviceResetN), 32'h1);
         fire <= '0;
         repeat (2) @(posedge clock);
         rtcEnable <= 1'b1;
      end
      fire <= 5'(1 << src);
      // count the exit reset; a master clear pulse inside it is ignored
      for (int g = 0; g < 100; g++) begin
         @(posedge clock);
         if (deviceResetN === 1'b0) n++;
         else if (n > 0) break;
         if (n == 1) fire <= '0;
         if (n == 3) fire <= 5'(1 << WAKE_MASTER_CLEAR_PIN_N);
         if (n == 5) fire <= '0;
      end
      check(32'(n), 32'(POR_N));
      rdChk(OFF_WAKE_SOURCE, 32'(1 << src), 32'h1f);
      rdChk(OFF_WAKE_SOURCE, 32'h0, 32'h1f);
      rdChk(OFF_RESET_CONTROL, 32'h400, 32'h400);
      apbWrite(OFF_RESET_CONTROL, 32'h0);
      rdChk(OFF_RESET_CONTROL, 32'h0, 32'h400);
      rdChk(OFF_SLEEP_CONTROL, (src == WAKE_WDT) ? 32'h7 : 32'h1, 32'h8007);
      apbWrite(OFF_SLEEP_CONTROL, 32'h0);
      rdChk(OFF_SLEEP_CONTROL, (src == WAKE_WDT) ? 32'h4 : 32'h0, 32'h8007);
      rdChk(OFF_CONTEXT_A, CTX_A, '1);
      rdChk(OFF_CONTEXT_B, CTX_B, '1);
      rdChk(OFF_INT_ENABLE, 32'h0, '1);
      // wake-done event: raised, masked, unmasked, cleared
      apbWrite(OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clock);
      check(32'(irq), 32'h1);
      apbWrite(OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clock);
      check(32'(irq), 32'h0);
      apbWrite(OFF_IRQ_MASK, 32'h1);
      apbWrite(OFF_IRQ_STATUS, 32'h3);
      repeat (2) @(posedge clock);
      check(32'(irq), 32'h0);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // watchdog: the whole run needs well under a thousand cycles; the limit is 20000
   initial begin
      #(8 * 20000);
      bad_count++;
      print_verdict();
   end
   // main sequence; the interrupt pin source runs once per polarity
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      regValues();
      apbWrite(OFF_CONTEXT_A, CTX_A);
      apbWrite(OFF_CONTEXT_B, CTX_B);
      for (int s = 0; s <= NUM_WAKE; s++) wakeCycle((s == NUM_WAKE) ? WAKE_EXTERNAL_INTERRUPT_ZERO_PIN : s, s != WAKE_EXTERNAL_INTERRUPT_ZERO_PIN);
      print_verdict();
   end
endmodule // deep_sleep_wake_exit_tb
